/* File: bench/esd_bus_partner.sv */
// Model of the bus master and DMA controller at the far side of the glue.
// Assumes the bench picks the burst kind and the stall of each cycle.
`timescale 1ns/1ps
module esd_bus_partner (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [1:0]  kind,
  input  wire logic        stall,
  input  wire logic        selN,
  input  wire logic        stbN,
  output logic             ackN,
  output logic             dirW,
  output logic             cycN,
  output logic             rdyN,
  output logic             noWaitN,
  output logic [31:0]      data
);
  logic [1:0]  kind_r;
  logic [31:0] word_r;

  // The no-wait request follows select but drops once the strobe rises.
  assign noWaitN = selN | stbN;
  assign ackN    = kind_r == 2'h0;
  assign dirW    = kind_r == 2'h1;
  assign cycN    = kind_r != 2'h1;
  assign rdyN    = stall;
  // Off-bus data shows the inverse word, so a stale hold cannot pass.
  assign data    = dirW ? word_r : ~word_r;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      {kind_r, word_r} <= '0;
    else if (!rdyN)
    begin
      kind_r <= kind;
      word_r <= word_r * 32'h0019660d + 32'h3c6ef35f;
    end
  end
endmodule : esd_bus_partner

/* File: bench/tb_top.sv */
// Self-checking bench: random decode, compressed and slave DMA traffic.
// Assumes esd_glue and esd_bus_partner are compiled before it.
`timescale 1ns/1ps
`define CHECK_EQ(act, exp, msg) begin checks++; if ((act) !== (exp)) \
  begin error_cnt++; $display("mismatch at %0t: %s", $time, msg); end end
module tb_top;
  localparam int LIMIT = 4000;
  logic                        ref_clk, rst, address_strobe_n, addrEnable;
  logic [esd_pkg::ADDR_W-1:0]  addrIn, latA;
  logic [esd_pkg::DEC_W-1:0]   decodeBase, decodeMask;
  logic                        local_device_select_n, noWaitReq_n, latAen;
  logic                        ioRead_n, ioWrite_n, compressedActive;
  logic                        compressedStrobe, dmaModeEnable, stall;
  logic                        datapath_select_n, dma_direction, expWv;
  logic                        dma_cycle_strobe_n, ready_return_n, expRb;
  logic                        busDataOe, pathWrValid, pathRdTake;
  logic                        regAccessSel, local_bus_mode_select_n;
  logic [esd_pkg::DATA_W-1:0]  busDataIn, busDataOut, pathWrData;
  logic [esd_pkg::DATA_W-1:0]  pathRdData, expWd, expRd;
  logic [1:0]                  kind, ccR;
  int                          seed, error_cnt, checks, cycles;

  esd_glue uut (.ref_clk, .rst, .address_strobe_n, .addrIn, .addrEnable,
    .decodeBase, .decodeMask, .local_device_select_n, .noWaitReq_n,
    .ioRead_n, .ioWrite_n, .compressedActive, .compressedStrobe,
    .local_bus_mode_select_n, .dmaModeEnable, .datapath_select_n,
    .dma_direction, .dma_cycle_strobe_n, .ready_return_n, .busDataIn,
    .busDataOut, .busDataOe, .pathWrValid, .pathWrData, .pathRdTake,
    .pathRdData, .regAccessSel);
  esd_bus_partner far (.ref_clk, .rst, .kind, .stall,
    .selN(local_device_select_n), .stbN(address_strobe_n),
    .ackN(datapath_select_n), .dirW(dma_direction),
    .cycN(dma_cycle_strobe_n), .rdyN(ready_return_n),
    .noWaitN(noWaitReq_n), .data(busDataIn));

  function automatic logic expSel(logic [13:0] a, logic en,
      logic [11:0] b, logic [11:0] m);
    return !((((a[13:2] ^ b) & m) == 12'h000) && !en);
  endfunction : expSel

  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic give_verdict();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  always @(posedge ref_clk)
    if (++cycles == LIMIT)
    begin
      error_cnt++;
      $display("mismatch at %0t: run timed out", $time);
      give_verdict();
    end

  // Inputs seen just before the edge decide what the edge must produce.
  task automatic score();
    if (ccR == 2'h0 && !noWaitReq_n && !local_device_select_n
        && !(ioRead_n && ioWrite_n))
      ccR = 2'h2;
    else if (ccR != 2'h0)
      ccR = ccR - 2'h1;
    expWv = dmaModeEnable & local_bus_mode_select_n & !datapath_select_n
            & dma_direction & !dma_cycle_strobe_n & !ready_return_n;
    expRb = dmaModeEnable & local_bus_mode_select_n & !datapath_select_n
            & !dma_direction & !ready_return_n;
    if (expWv)
      expWd = busDataIn;
    if (expRb)
      expRd = pathRdData;
  endtask : score

  // The first 40 cycles are fixed corners: a stalled write burst, then a
  // read burst, with compressed starts pressed back to back throughout.
  task automatic drive(input int i);
    logic [31:0] r;
    logic [31:0] s;
    r = $random(seed);
    s = $random(seed);
    if (i < 40 || !r[0])
    begin
      latA = {decodeBase ^ ((r[3:1] == 3'h0) ? s[11:0] : 12'h000),
              s[13:12]};
      latAen = (i >= 40) && (r[6:4] == 3'h0);
    end
    // With the strobe high the pins carry junk, so only a true hold of the
    // copy seen at the strobe's rise keeps the select right.
    addrIn <= (i < 40 || !r[0]) ? latA : ~latA;
    addrEnable <= (i < 40 || !r[0]) ? latAen : ~latAen;
    address_strobe_n <= (i >= 40) && r[0];
    ioRead_n <= (i >= 40) && (r[9:7] != 3'h0);
    ioWrite_n <= r[12:10] != 3'h0;
    dmaModeEnable <= (i < 40) || (r[16:13] != 4'h0);
    local_bus_mode_select_n <= (i < 40) || (r[26:25] != 2'h0);
    stall <= (i < 16) ? i[0] : (i == 25 || r[18:17] == 2'h0);
    if (i < 40)
      kind <= (i < 16) ? 2'h1 : ((i < 20) ? 2'h0 : 2'h2);
    else if (r[22:19] == 4'h0)
      kind <= (r[24:23] == 2'h3) ? 2'h0 : r[24:23];
    pathRdData <= s;
    if (i[7:0] == 8'hff)
    begin
      decodeBase <= s[23:12];
      decodeMask <= r[31:20] | s[31:20];
    end
  endtask : drive

  task automatic check();
    logic e;
    logic a;
    logic d;
    e = expSel(latA, latAen, decodeBase, decodeMask);
    a = dmaModeEnable & local_bus_mode_select_n & !datapath_select_n;
    d = a & !dma_direction;
    `CHECK_EQ(local_device_select_n, e, "select")
    `CHECK_EQ(compressedActive, ccR != 2'h0, "active")
    `CHECK_EQ(compressedStrobe, ccR == 2'h2, "strobe")
    `CHECK_EQ(pathWrValid, expWv, "write beat")
    if (expWv) `CHECK_EQ(pathWrData, expWd, "write data")
    if (expRb) `CHECK_EQ(busDataOut, expRd, "read data")
    `CHECK_EQ(pathRdTake, d & !ready_return_n, "read take")
    `CHECK_EQ(busDataOe, d, "drive")
    `CHECK_EQ(regAccessSel, !a & !e, "register path")
  endtask : check

  initial
  begin
    seed = 79363;
    error_cnt = 0;
    checks = 0;
    cycles = 0;
    ccR = 2'h0;
    {rst, address_strobe_n, addrEnable, ioRead_n, ioWrite_n} = 5'h1f;
    {kind, stall, dmaModeEnable, latAen} = 5'h01;
    local_bus_mode_select_n = 1'b1;
    {addrIn, latA, pathRdData} = '0;
    decodeBase = esd_pkg::DEC_BASE_RST;
    decodeMask = esd_pkg::DEC_MASK_RST;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    for (int i = 0; i < 3000; i++)
    begin
      @(posedge ref_clk);
      score();
      drive(i);
      @(negedge ref_clk);
      check();
    end
    give_verdict();
  end
endmodule : tb_top

/* File: logic/esd_addr_latch.sv */
// Address and enable latch for the I/O decode path.
// Assumes the address strobe and address qualifier are synchronous inputs.
`timescale 1ns/1ps
module esd_addr_latch (
  input  wire logic                          ref_clk,
  input  wire logic                          rst,
  input  wire logic                          address_strobe_n,
  input  wire logic [esd_pkg::ADDR_W-1:0]    addrIn,
  input  wire logic                          addrEnable,
  output logic      [esd_pkg::ADDR_W-1:0]    addrLatched,
  output logic                               aenLatched,
  output logic                               strobeRise
);

  logic strobeN_r;
  logic [esd_pkg::ADDR_W-1:0] addr_r;
  logic aen_r;

  // -----------------------------------------------------------------------
  // Transparent while the strobe is low, held from its trailing edge
  // -----------------------------------------------------------------------
  assign strobeRise  = address_strobe_n & ~strobeN_r;
  assign addrLatched = address_strobe_n ? addr_r : addrIn;  // see R10
  assign aenLatched  = address_strobe_n ? aen_r : addrEnable;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      strobeN_r <= 1'b1;
      addr_r    <= '0;
      aen_r     <= 1'b1;
    end
    else
    begin
      strobeN_r <= address_strobe_n;
      if (!address_strobe_n)
      begin
        addr_r <= addrIn;  // see R10
        aen_r  <= addrEnable;
      end
    end
  end

  strobe_held_a: assert property (  // see R10
    @(posedge ref_clk) disable iff (rst)
    address_strobe_n && $past(address_strobe_n) |-> $stable(addr_r))
    else $error("Latched address moved while strobe high.");

endmodule : esd_addr_latch

/* File: logic/esd_glue.sv */
// Bus glue: local device select decode, compressed cycle timing and slave
// DMA burst data path. Assumes the bus clock drives ref_clk and that the
// bus master keeps its own obligations.
//
// Summary of operation
// R1 - Select low on address match and enable low.
// R2 - Master ends no-wait request at strobe rise.
// R3 - Compressed cycle: 1.5 clocks, half-clock strobe. The glue holds compressedActive for 2 whole clocks and compressedStrobe for 1.
// R4 - Bus clock times all DMA bursts.
// R5 - DMA acknowledge held for whole cycle.
// R6 - Acknowledge routes beats straight to data path.
// R7 - Direction high on write; cycle strobe marks writes.
// R8 - Not ready postpones the next beat.
// R9 - Ready pin used only in DMA mode.
// R10 - Address latched at strobe trailing edge.
`timescale 1ns/1ps
module esd_glue (
  input  wire logic                        ref_clk,
  input  wire logic                        rst,
  input  wire logic                        address_strobe_n,
  input  wire logic [esd_pkg::ADDR_W-1:0]  addrIn,
  input  wire logic                        addrEnable,
  input  wire logic [esd_pkg::DEC_W-1:0]   decodeBase,
  input  wire logic [esd_pkg::DEC_W-1:0]   decodeMask,
  output logic                             local_device_select_n,
  input  wire logic                        noWaitReq_n,
  input  wire logic                        ioRead_n,
  input  wire logic                        ioWrite_n,
  output logic                             compressedActive,
  output logic                             compressedStrobe,
  input  wire logic                        local_bus_mode_select_n,
  input  wire logic                        dmaModeEnable,
  input  wire logic                        datapath_select_n,
  input  wire logic                        dma_direction,
  input  wire logic                        dma_cycle_strobe_n,
  input  wire logic                        ready_return_n,
  input  wire logic [esd_pkg::DATA_W-1:0]  busDataIn,
  output logic      [esd_pkg::DATA_W-1:0]  busDataOut,
  output logic                             busDataOe,
  output logic                             pathWrValid,
  output logic      [esd_pkg::DATA_W-1:0]  pathWrData,
  output logic                             pathRdTake,
  input  wire logic [esd_pkg::DATA_W-1:0]  pathRdData,
  output logic                             regAccessSel
);

  logic [esd_pkg::ADDR_W-1:0] addrLatched;
  logic                       aenLatched;
  logic                       strobeRise;

  esd_addr_latch u_latch (
    .ref_clk          (ref_clk),
    .rst              (rst),
    .address_strobe_n (address_strobe_n),
    .addrIn           (addrIn),
    .addrEnable       (addrEnable),
    .addrLatched      (addrLatched),
    .aenLatched       (aenLatched),
    .strobeRise       (strobeRise)
  );

  // -----------------------------------------------------------------------
  // Local device decode
  // -----------------------------------------------------------------------
  wire [esd_pkg::DEC_W-1:0] decField =
    addrLatched[esd_pkg::DEC_LSB +: esd_pkg::DEC_W];
  wire decHit = ((decField ^ decodeBase) & decodeMask) == '0;
  // The select is combinational so it tracks the latched address at once.
  assign local_device_select_n = ~(decHit & ~aenLatched);  // see R1

  // -----------------------------------------------------------------------
  // Compressed cycle: the strobe half-period is the clock low phase, so the
  // qualified strobe is emitted as a flag for the pad logic to AND with it.
  // -----------------------------------------------------------------------
  logic [1:0] compCnt_r;
  logic [1:0] compCnt_nxt;
  wire ioStrobe  = ~ioRead_n | ~ioWrite_n;
  wire compStart = ~noWaitReq_n & ~local_device_select_n & ioStrobe &
                   (compCnt_r == 2'h0);
  assign compCnt_nxt = compStart ? 2'(esd_pkg::COMP_CYCLES) :
                       (compCnt_r != 2'h0) ? compCnt_r - 2'h1 : 2'h0;
  assign compressedActive = compCnt_r != 2'h0;  // see R3
  assign compressedStrobe = compCnt_r == 2'(esd_pkg::COMP_CYCLES);  // see R3

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      compCnt_r <= 2'h0;
    else
      compCnt_r <= compCnt_nxt;
  end

  // -----------------------------------------------------------------------
  // Slave DMA burst, clocked by the bus clock
  // -----------------------------------------------------------------------
  esd_pkg::esd_dma_e state_r;
  esd_pkg::esd_dma_e state_nxt;
  logic [esd_pkg::DATA_W-1:0] wrData_r;
  logic [esd_pkg::DATA_W-1:0] rdData_r;
  logic wrValid_r;

  // The ready pin only means bus ready in DMA mode; elsewhere it is ignored.
  wire dmaMode  = dmaModeEnable & local_bus_mode_select_n;
  wire busReady = dmaMode ? ~ready_return_n : 1'b1;  // see R9
  wire dmaSel   = dmaMode & ~datapath_select_n;  // see R5
  wire wrBeat   = dmaSel & dma_direction & ~dma_cycle_strobe_n &
                  busReady;  // see R7 see R8
  wire rdBeat   = dmaSel & ~dma_direction & busReady;  // see R7 see R8

  assign regAccessSel = ~dmaSel & ~local_device_select_n;  // see R6
  assign pathWrValid  = wrValid_r;
  assign pathWrData   = wrData_r;
  assign pathRdTake   = rdBeat;
  assign busDataOut   = rdData_r;
  assign busDataOe    = dmaSel & ~dma_direction;

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      esd_pkg::ESD_IDLE,
      esd_pkg::ESD_WRITE,
      esd_pkg::ESD_READ,
      esd_pkg::ESD_WAIT:
      begin
        if (!dmaSel)
          state_nxt = esd_pkg::ESD_IDLE;
        else if (!busReady)
          state_nxt = esd_pkg::ESD_WAIT;
        else if (wrBeat)
          state_nxt = esd_pkg::ESD_WRITE;
        else if (rdBeat)
          state_nxt = esd_pkg::ESD_READ;
        else
          state_nxt = esd_pkg::ESD_WAIT;
      end
      default:
        state_nxt = esd_pkg::ESD_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst)  // see R4
  begin
    if (rst)
    begin
      state_r   <= esd_pkg::ESD_IDLE;
      wrData_r  <= '0;
      rdData_r  <= '0;
      wrValid_r <= 1'b0;
    end
    else
    begin
      state_r   <= state_nxt;
      wrValid_r <= wrBeat;  // see R6
      if (wrBeat)
        wrData_r <= busDataIn;
      if (rdBeat)
        rdData_r <= pathRdData;
    end
  end

  // -----------------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------------
  sequence notReadyBeat;
    dmaMode && dmaSel && ready_return_n;
  endsequence

  // Strobe cycle, then the second half cycle, then back to idle.
  sequence compRun;
    compressedStrobe ##1 (compressedActive && !compressedStrobe)
    ##1 !compressedActive;
  endsequence

  select_decode_a: assert property (  // see R1
    @(posedge ref_clk) disable iff (rst)
    (decHit && !aenLatched) == !local_device_select_n)
    else $error("Select does not follow the decode.");

  comp_length_a: assert property (  // see R3
    @(posedge ref_clk) disable iff (rst)
    compStart |=> compRun)
    else $error("Compressed cycle has wrong length.");

  stall_write_a: assert property (  // see R8
    @(posedge ref_clk) disable iff (rst)
    notReadyBeat |=> !wrValid_r)
    else $error("Beat advanced while bus not ready.");

  stall_wait_a: assert property (  // see R8
    @(posedge ref_clk) disable iff (rst)
    notReadyBeat |=> state_r == esd_pkg::ESD_WAIT)
    else $error("Burst did not wait while bus not ready.");

  stall_read_a: assert property (  // see R8
    @(posedge ref_clk) disable iff (rst)
    dmaMode && ready_return_n |-> !pathRdTake)
    else $error("Read beat taken while not ready.");

  ready_ignored_a: assert property (  // see R9
    @(posedge ref_clk) disable iff (rst)
    !dmaMode |-> busReady)
    else $error("Ready pin used outside DMA mode.");

  write_capture_a: assert property (  // see R6
    @(posedge ref_clk) disable iff (rst)
    wrBeat |=> pathWrValid && pathWrData == $past(busDataIn))
    else $error("Write beat data not passed to data path.");

  read_dir_a: assert property (  // see R7
    @(posedge ref_clk) disable iff (rst)
    pathRdTake |-> !dma_direction && busDataOe)
    else $error("Read beat with write direction.");

  write_strobe_a: assert property (  // see R7
    @(posedge ref_clk) disable iff (rst)
    pathWrValid |-> $past(!dma_cycle_strobe_n && dma_direction))
    else $error("Write beat without cycle strobe.");

  no_decode_a: assert property (  // see R6
    @(posedge ref_clk) disable iff (rst)
    dmaSel |-> !regAccessSel)
    else $error("Register decode active during DMA.");

  // The decode must see the address as it stood on the last low cycle.
  latch_rise_a: assert property (  // see R10
    @(posedge ref_clk) disable iff (rst)
    strobeRise |-> addrLatched == $past(addrIn))
    else $error("Address not held from the strobe rise.");

endmodule : esd_glue

/* File: pkg/esd_pkg.sv */
// Package for the bus-side decode and slave DMA burst glue.
// Assumes one synchronous clock (ref_clk, 10 MHz) standing in for the bus
// clock, and inputs already synchronous to it.
package esd_pkg;

  // ---------------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------------
  localparam int unsigned ADDR_W        = 14;           // Address bits 15..2.
  localparam int unsigned DEC_LSB       = 2;            // Bit 4 within field.
  localparam int unsigned DEC_W         = 12;           // Bits 15..4 compared.
  localparam logic [11:0] DEC_BASE_RST  = 12'h030;      // Default I/O base.
  localparam logic [11:0] DEC_MASK_RST  = 12'hfff;      // All bits compared.

  // ---------------------------------------------------------------------
  // Data path and timing
  // ---------------------------------------------------------------------
  localparam int unsigned DATA_W        = 32;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned COMP_CYC_HALF = 3;            // 1.5 clocks in halves.
  localparam int unsigned COMP_STB_HALF = 1;            // 0.5 clock strobe.
  // Whole cycles a compressed access occupies, rounded up.
  localparam int unsigned COMP_CYCLES   = (COMP_CYC_HALF + 1) / 2;

  typedef enum logic [1:0] {
    ESD_IDLE,
    ESD_WRITE,
    ESD_READ,
    ESD_WAIT
  } esd_dma_e;

endpackage : esd_pkg
